// ---- shared/nfcomc_regs.vh ----
`ifndef NFCOMC_REGS_VH
`define NFCOMC_REGS_VH
// Byte addresses on the register bus
`define NFCOMC_OFF_OPCTRL     8'h08
`define NFCOMC_OFF_MODEDEF    8'h0C
`define NFCOMC_OFF_EVENTS     8'h10
`define NFCOMC_OFF_STATUS     8'h14
`define NFCOMC_OFF_PREFIX     8'h18
// Register indices as printed
`define NFCOMC_IDX_OPCTRL     8'h02
`define NFCOMC_IDX_MODEDEF    8'h03
// Operation control fields
`define NFCOMC_OC_READY       7
`define NFCOMC_OC_RX_EN       6
`define NFCOMC_OC_RX_ONECH    5
`define NFCOMC_OC_RX_MAN      4
`define NFCOMC_OC_TX_EN       3
`define NFCOMC_OC_WAKEUP      2
`define NFCOMC_OC_FD_HI       1
`define NFCOMC_OC_FD_LO       0
`define NFCOMC_OC_RESET       8'h00
// Mode definition fields
`define NFCOMC_MD_TARGET      7
`define NFCOMC_MD_PS_HI       6
`define NFCOMC_MD_PS_LO       3
`define NFCOMC_MD_MODSTYLE    2
`define NFCOMC_MD_RESET       8'h08
`define NFCOMC_MD_WMASK       8'hFC
// Field detector control codes
`define NFCOMC_FD_OFF         2'h0
`define NFCOMC_FD_COLLAV      2'h1
`define NFCOMC_FD_PEER        2'h2
`define NFCOMC_FD_AUTO        2'h3
// Protocol select codes
`define NFCOMC_PS_TYPE_A      4'h1
`define NFCOMC_PS_TYPE_B      4'h2
`define NFCOMC_PS_TYPE_1      4'h4
`define NFCOMC_PS_SUBC        4'hE
`define NFCOMC_PS_BPSK        4'hF
`define NFCOMC_PS_TGT_F       4'h4
// Transport frame bytes
`define NFCOMC_START_BYTE     8'hF0
// AXI responses
`define NFCOMC_RESP_OKAY      2'h0
`define NFCOMC_RESP_SLVERR    2'h2
`endif

// ---- rtl/nfcomc_top.v ----
`timescale 1ns/10ps
`include "nfcomc_regs.vh"
// Contract
// [RULE1] Top control bit powers oscillator and regulators, Ready state.
// [RULE2] Bit 6 enables the receiver.
// [RULE3] Bit 5 chooses both AM/PM channels or one chosen channel.
// [RULE4] Bit 4 picks automatic or manual channel choice with both channels.
// [RULE5] Bit 3 enables the transmitter.
// [RULE6] Field-on sets transmit enable; active peer transmit end clears it.
// [RULE7] Bit 2 enables wake-up mode.
// [RULE8] Bits 1:0 decode field detector off, collision, peer, automatic.
// [RULE9] Host uses collision threshold code for reader field-on work.
// [RULE10] Host uses automatic code for active peer and passive target.
// [RULE11] Detector on with all other bits zero gives low power listening.
// [RULE12] Operation control defaults load at power-up only.
// [RULE13] Mode register holds role bit and four-bit protocol code, reset 0001.
// [RULE14] Bit 2 of mode register picks on-off keying or amplitude modulation.
// [RULE15] Mode register writes accepted only while crystal stable.
// [RULE16] Initiator codes: type A, B, Type 1, sub-carrier, BPSK stream.
// [RULE17] Unsupported initiator code disables transmit and receive.
// [RULE18] Target codes: type A, type F, bit rate detection with enables.
// [RULE19] Host keeps prefix option off in bit rate detection.
// [RULE20] Prefix option adds start and length bytes on transmit.
// [RULE21] Mode register bits 1:0 read zero and ignore writes.
module nfcomc_top (
   input  wire        clk,
   input  wire        nrst,
   input  wire        ce,
   input  wire        por_n,
   input  wire        xtal_stable_pin,
   input  wire        field_on_cmd,
   input  wire        tx_done,
   input  wire        receiver_channel_choice,
   input  wire [7:0]  tx_len,
   input  wire        rx_byte_valid,
   input  wire        rx_first_byte,
   input  wire [31:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [31:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output reg         osc_reg_on,
   output reg         rx_enable,
   output reg         rx_am_on,
   output reg         rx_pm_on,
   output reg         rx_auto_select,
   output reg         tx_enable,
   output reg         wakeup_mode_on,
   output reg  [1:0]  field_detect_ctrl,
   output reg         fd_thr_peer,
   output reg         fd_auto,
   output reg         low_power_listen,
   output reg         target_role,
   output reg  [3:0]  protocol_select,
   output reg         modulation_style,
   output reg         mode_supported,
   output reg         brd_type_a,
   output reg         brd_type_f,
   output reg         transport_frame_prefix,
   output reg         tx_add_prefix,
   output reg  [7:0]  tx_prefix_byte0,
   output reg  [7:0]  tx_prefix_byte1,
   output reg         rx_skip_byte
);

   reg  [7:0]  opctrl_q;
   reg  [7:0]  opctrl_d;
   reg  [7:0]  modedef_q;
   reg         prefix_q;
   reg  [2:0]  xtal_sync_q;
   reg         xtal_ok_q;
   reg         ign_q;
   reg  [7:0]  aw_q;
   reg         aw_full_q;
   reg  [31:0] wd_q;
   reg  [3:0]  ws_q;
   reg         w_full_q;
   wire        do_write;
   wire        do_read;
   wire        mode_ok;
   wire        active_peer_mode_w;
   wire        tx_clear_w;
   wire        wr_opctrl_w;
   wire        wr_modedef_w;
   wire        wr_prefix_w;
   wire        rd_events_w;
   wire [31:0] status_word_w;

   // Mode code support check per role
   function supported;
      input       tgt;
      input [3:0] ps;
      begin
         if (tgt) begin
            supported = (ps == `NFCOMC_PS_TYPE_A) || (ps == `NFCOMC_PS_TGT_F) || ps[3];
         end else begin
            supported = (ps == `NFCOMC_PS_TYPE_A) || (ps == `NFCOMC_PS_TYPE_B) ||
                        (ps == `NFCOMC_PS_TYPE_1) || (ps == `NFCOMC_PS_SUBC) ||
                        (ps == `NFCOMC_PS_BPSK);
         end
      end
   endfunction

   // Register hit: byte address match with lane 0 strobed
   function reg_hit;
      input [7:0] addr;
      input [7:0] off;
      input       lane0;
      begin
         reg_hit = (addr == off) && lane0;
      end
   endfunction

   // Crystal stable pin synchroniser
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         xtal_sync_q <= 3'h0;
         xtal_ok_q   <= 1'b0;
      end else if (ce) begin
         xtal_sync_q <= {xtal_sync_q[1:0], xtal_stable_pin};
         if (xtal_sync_q[2] == xtal_sync_q[1]) begin
            xtal_ok_q <= xtal_sync_q[2];
         end
      end
   end

   // Write address and data captured in either order
   assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_full_q && !s_axi_bvalid;
   assign do_write      = aw_full_q && w_full_q && !s_axi_bvalid;
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         aw_q         <= 8'h00;
         aw_full_q    <= 1'b0;
         wd_q         <= 32'h0000_0000;
         ws_q         <= 4'h0;
         w_full_q     <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `NFCOMC_RESP_OKAY;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q      <= s_axi_awaddr[7:0];
            aw_full_q <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wd_q     <= s_axi_wdata;
            ws_q     <= s_axi_wstrb;
            w_full_q <= 1'b1;
         end
         if (do_write) begin
            aw_full_q    <= 1'b0;
            w_full_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (aw_q)
               `NFCOMC_OFF_OPCTRL, `NFCOMC_OFF_MODEDEF, `NFCOMC_OFF_PREFIX: begin
                  s_axi_bresp <= `NFCOMC_RESP_OKAY;
               end
               default: begin
                  s_axi_bresp <= `NFCOMC_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Register strobes shared by several processes
   assign wr_opctrl_w  = do_write && reg_hit(aw_q, `NFCOMC_OFF_OPCTRL, ws_q[0]);
   assign wr_modedef_w = do_write && reg_hit(aw_q, `NFCOMC_OFF_MODEDEF, ws_q[0]);
   assign wr_prefix_w  = do_write && reg_hit(aw_q, `NFCOMC_OFF_PREFIX, ws_q[0]);
   assign rd_events_w  = do_read && reg_hit(s_axi_araddr[7:0], `NFCOMC_OFF_EVENTS, 1'b1);

   // Active peer: detector in automatic mode
   assign active_peer_mode_w = (opctrl_q[1:0] == `NFCOMC_FD_AUTO);
   // [RULE6] Transmission end in active peer work
   assign tx_clear_w = tx_done && opctrl_q[`NFCOMC_OC_TX_EN] && active_peer_mode_w;

   // Operation control next value
   always @* begin
      opctrl_d = opctrl_q;
      if (wr_opctrl_w) begin
         opctrl_d = wd_q[7:0];
      end
      // [RULE6] Automatic tx clear
      if (tx_clear_w) begin
         opctrl_d[`NFCOMC_OC_TX_EN] = 1'b0;
      end
      // [RULE6] Field-on sets tx, wins
      if (field_on_cmd) begin
         opctrl_d[`NFCOMC_OC_TX_EN] = 1'b1;
      end
   end

   // [RULE12] Defaults at power-up only
   always @(posedge clk or negedge por_n) begin
      if (!por_n) begin
         opctrl_q <= `NFCOMC_OC_RESET;
      end else if (ce) begin
         opctrl_q <= opctrl_d;
      end
   end

   // Mode register and prefix option
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         modedef_q <= `NFCOMC_MD_RESET;
         prefix_q  <= 1'b0;
      end else if (ce) begin
         if (wr_modedef_w) begin
            // [RULE15] Crystal gated write
            if (xtal_ok_q) begin
               // [RULE21] Reserved bits stay zero
               modedef_q <= wd_q[7:0] & `NFCOMC_MD_WMASK;
            end
         end
         if (wr_prefix_w) begin
            prefix_q <= wd_q[0];
         end
      end
   end

   // [RULE15] Refused mode write event, set beats read clear
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ign_q <= 1'b0;
      end else if (ce) begin
         if (wr_modedef_w && !xtal_ok_q) begin
            ign_q <= 1'b1;
         end else if (rd_events_w) begin
            ign_q <= 1'b0;
         end
      end
   end

   // Read channel
   assign s_axi_arready = !s_axi_rvalid;
   assign do_read       = s_axi_arvalid && s_axi_arready;
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `NFCOMC_RESP_OKAY;
      end else if (ce) begin
         if (do_read) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `NFCOMC_RESP_OKAY;
            case (s_axi_araddr[7:0])
               `NFCOMC_OFF_OPCTRL:  s_axi_rdata <= {24'h000000, opctrl_q};
               `NFCOMC_OFF_MODEDEF: s_axi_rdata <= {24'h000000, modedef_q};
               `NFCOMC_OFF_EVENTS:  s_axi_rdata <= {31'h0, ign_q};
               `NFCOMC_OFF_STATUS:  s_axi_rdata <= status_word_w;
               `NFCOMC_OFF_PREFIX:  s_axi_rdata <= {31'h0, prefix_q};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `NFCOMC_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   assign mode_ok = supported(modedef_q[7], modedef_q[6:3]);
   // Status word: listening, code supported, crystal ok
   assign status_word_w = {29'h0, low_power_listen, mode_supported, xtal_ok_q};

   // Decoded control outputs
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         osc_reg_on             <= 1'b0;
         rx_enable              <= 1'b0;
         rx_am_on               <= 1'b0;
         rx_pm_on               <= 1'b0;
         rx_auto_select         <= 1'b0;
         tx_enable              <= 1'b0;
         wakeup_mode_on         <= 1'b0;
         field_detect_ctrl      <= `NFCOMC_FD_OFF;
         fd_thr_peer            <= 1'b0;
         fd_auto                <= 1'b0;
         low_power_listen       <= 1'b0;
         target_role            <= 1'b0;
         protocol_select        <= 4'h1;
         modulation_style       <= 1'b0;
         mode_supported         <= 1'b1;
         brd_type_a             <= 1'b0;
         brd_type_f             <= 1'b0;
         transport_frame_prefix <= 1'b0;
         tx_add_prefix          <= 1'b0;
         tx_prefix_byte0        <= 8'h00;
         tx_prefix_byte1        <= 8'h00;
         rx_skip_byte           <= 1'b0;
      end else if (ce) begin
         // [RULE1] Oscillator and regulator
         osc_reg_on     <= opctrl_q[`NFCOMC_OC_READY];
         // [RULE2] [RULE17] Receive enable
         rx_enable      <= opctrl_q[`NFCOMC_OC_RX_EN] && mode_ok;
         // [RULE3] Channel arrangement
         rx_am_on       <= !opctrl_q[`NFCOMC_OC_RX_ONECH] || !receiver_channel_choice;
         rx_pm_on       <= !opctrl_q[`NFCOMC_OC_RX_ONECH] || receiver_channel_choice;
         // [RULE4] Auto channel selection
         rx_auto_select <= !opctrl_q[`NFCOMC_OC_RX_ONECH] && !opctrl_q[`NFCOMC_OC_RX_MAN];
         // [RULE5] [RULE17] Transmit enable
         tx_enable      <= opctrl_q[`NFCOMC_OC_TX_EN] && mode_ok;
         // [RULE7] Wake-up mode
         wakeup_mode_on <= opctrl_q[`NFCOMC_OC_WAKEUP];
         // [RULE8] Field detector decode
         field_detect_ctrl <= opctrl_q[1:0];
         fd_thr_peer    <= opctrl_q[1:0] == `NFCOMC_FD_PEER;
         fd_auto        <= opctrl_q[1:0] == `NFCOMC_FD_AUTO;
         // [RULE11] Low power listening
         low_power_listen <= (opctrl_q[1:0] != `NFCOMC_FD_OFF) && (opctrl_q[7:2] == 6'h00);
         // [RULE13] [RULE14] Role, code, modulation
         target_role      <= modedef_q[`NFCOMC_MD_TARGET];
         protocol_select  <= modedef_q[6:3];
         modulation_style <= modedef_q[`NFCOMC_MD_MODSTYLE];
         // [RULE16] [RULE18] Code support
         mode_supported   <= mode_ok;
         brd_type_a       <= modedef_q[7] && modedef_q[6] && modedef_q[3];
         brd_type_f       <= modedef_q[7] && modedef_q[6] && modedef_q[5];
         // [RULE20] Transport frame prefix
         transport_frame_prefix <= prefix_q;
         tx_add_prefix    <= prefix_q;
         tx_prefix_byte0  <= prefix_q ? `NFCOMC_START_BYTE : 8'h00;
         tx_prefix_byte1  <= prefix_q ? tx_len : 8'h00;
         rx_skip_byte     <= prefix_q && rx_byte_valid && rx_first_byte;
      end
   end

endmodule // nfcomc_top

// ---- sim/nfcomc_monitor.sv ----
`timescale 1ns/10ps
module nfcomc_monitor (
   input logic       clk, nrst, ce, por_n, field_on_cmd, tx_done,
   input logic [7:0] tx_len, tx_prefix_byte0, tx_prefix_byte1,
   input logic       s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_bvalid, s_axi_bready,
   input logic [1:0] s_axi_bresp, field_detect_ctrl,
   input logic       tx_enable, rx_enable, osc_reg_on, wakeup_mode_on, fd_thr_peer, fd_auto,
   input logic       low_power_listen, target_role, mode_supported, brd_type_a, brd_type_f, tx_add_prefix,
   input logic [3:0] protocol_select
);
   // One domain, either reset stops checking
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst || !por_n);
   // Decode and gating relations
   chk_lpl_state: assert property (low_power_listen |->
      field_detect_ctrl != 2'h0 && !osc_reg_on && !wakeup_mode_on)
      else $error("listen state with other bits set");
   chk_fd_peer: assert property (fd_thr_peer == (field_detect_ctrl == 2'h2))
      else $error("peer threshold decode wrong");
   chk_fd_auto: assert property (fd_auto == (field_detect_ctrl == 2'h3))
      else $error("auto detector decode wrong");
   chk_unsup_gate: assert property (!mode_supported |-> !tx_enable && !rx_enable)
      else $error("tx or rx on with bad mode");
   chk_init_codes: assert property (!target_role |->
      mode_supported == (protocol_select inside {4'h1, 4'h2, 4'h4, 4'hE, 4'hF}))
      else $error("initiator code support wrong");
   chk_brd_flags: assert property (target_role && protocol_select[3] |->
      brd_type_f == protocol_select[2] && brd_type_a == protocol_select[0])
      else $error("rate detect enables wrong");
   chk_prefix_start: assert property (tx_add_prefix |-> tx_prefix_byte0 == 8'hF0)
      else $error("start byte wrong");
   chk_prefix_len: assert property (tx_add_prefix |=> !tx_add_prefix || tx_prefix_byte1 == $past(tx_len))
      else $error("length byte wrong");
   chk_field_on: assert property (ce && field_on_cmd && mode_supported |-> ##[1:3] tx_enable)
      else $error("field on did not enable tx");
   chk_tx_done: assert property (ce && tx_done && !field_on_cmd && field_detect_ctrl == 2'h3 |->
      ##[1:3] !tx_enable)
      else $error("tx done did not clear tx");
   chk_read_ans: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   cov_listen: cover property (low_power_listen);
   cov_unsup: cover property (!mode_supported);
   cov_prefix: cover property (tx_add_prefix);
endmodule // nfcomc_monitor
bind nfcomc_top nfcomc_monitor nfcomc_monitor_inst (.*);

// ---- sim/tb_top.sv ----
`timescale 1ns/10ps
`include "nfcomc_regs.vh"
module tb_top;
   logic        clk, nrst, ce, por_n, xtal_stable_pin, field_on_cmd, tx_done, receiver_channel_choice;
   logic        rx_byte_valid, rx_first_byte, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        osc_reg_on, rx_enable, rx_am_on, rx_pm_on, rx_auto_select, tx_enable, wakeup_mode_on;
   logic        fd_thr_peer, fd_auto, low_power_listen, target_role, modulation_style, mode_supported;
   logic        brd_type_a, brd_type_f, transport_frame_prefix, tx_add_prefix, rx_skip_byte;
   logic [1:0]  s_axi_bresp, s_axi_rresp, field_detect_ctrl, rsp;
   logic [3:0]  s_axi_wstrb, protocol_select;
   logic [7:0]  tx_len, tx_prefix_byte0, tx_prefix_byte1;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_d;
   int          miscompares, total_checks, i;
   nfcomc_top nfcomc_top_inst (.*);
   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Compare and count
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s exp %0h got %0h", nm, exp, got);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic tmo(input int n);
      if (n >= 40) begin
         miscompares++;
         print_verdict();
      end
   endtask
   // Write: hold each channel until taken, then wait for response
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      s_axi_awaddr <= {24'h000000, a};
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      tmo(n);
      wt(3);
   endtask
   // Read: address held until taken, data taken at rvalid edge
   task automatic rd(input logic [7:0] a);
      int n;
      s_axi_araddr <= {24'h000000, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      rd_d = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      tmo(n);
      wt(1);
   endtask
   // One-cycle command pulse
   task automatic pulse(input logic f);
      if (f) field_on_cmd <= 1'b1;
      else tx_done <= 1'b1;
      @(posedge clk);
      {field_on_cmd, tx_done} <= 2'h0;
      wt(3);
   endtask
   initial begin
      {nrst, por_n, ce, xtal_stable_pin, field_on_cmd, tx_done, receiver_channel_choice} = 7'h10;
      {rx_byte_valid, rx_first_byte, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
      {s_axi_arvalid, s_axi_rready, s_axi_wstrb, tx_len} = 14'h0F5A;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      wt(5);
      nrst <= 1'b1;
      por_n <= 1'b1;
      wt(1);
      rd(`NFCOMC_OFF_OPCTRL);
      chk("opctrl_rst", rd_d, 32'h00000000);
      rd(`NFCOMC_OFF_MODEDEF);
      chk("modedef_rst", rd_d, 32'h00000008);
      chk("ps_rst", protocol_select, 4'h1);
      $display("test reset done");
      wr(`NFCOMC_OFF_OPCTRL, 8'hC4);
      chk("osc", osc_reg_on, 1'b1);
      chk("rx_en", rx_enable, 1'b1);
      chk("both_ch", {rx_am_on, rx_pm_on}, 2'h3);
      chk("auto_sel", rx_auto_select, 1'b1);
      chk("wakeup", wakeup_mode_on, 1'b1);
      chk("tx_off", tx_enable, 1'b0);
      receiver_channel_choice <= 1'b1;
      wr(`NFCOMC_OFF_OPCTRL, 8'h70);
      chk("one_ch", {rx_am_on, rx_pm_on}, 2'h1);
      wr(`NFCOMC_OFF_OPCTRL, 8'h50);
      chk("man_sel", rx_auto_select, 1'b0);
      $display("test opctrl done");
      for (i = 0; i < 4; i++) begin
         wr(`NFCOMC_OFF_OPCTRL, i[7:0]);
         chk("fd_ctrl", field_detect_ctrl, i[1:0]);
         chk("fd_peer", fd_thr_peer, i == 2);
         chk("fd_auto", fd_auto, i == 3);
         chk("lp_listen", low_power_listen, i != 0);
      end
      wr(`NFCOMC_OFF_OPCTRL, 8'h81);
      chk("lp_listen_en", low_power_listen, 1'b0);
      $display("test detector done");
      wr(`NFCOMC_OFF_OPCTRL, 8'h88);
      chk("tx_on", tx_enable, 1'b1);
      // Reader work: collision threshold before field-on
      wr(`NFCOMC_OFF_OPCTRL, 8'h81);
      pulse(1'b1);
      rd(`NFCOMC_OFF_OPCTRL);
      chk("field_on", rd_d, 32'h00000089);
      chk("tx_field_on", tx_enable, 1'b1);
      wr(`NFCOMC_OFF_OPCTRL, 8'h8B);
      pulse(1'b0);
      rd(`NFCOMC_OFF_OPCTRL);
      chk("tx_done", rd_d, 32'h00000083);
      chk("tx_cleared", tx_enable, 1'b0);
      {field_on_cmd, tx_done} <= 2'h3;
      wt(1);
      {field_on_cmd, tx_done} <= 2'h0;
      wt(3);
      rd(`NFCOMC_OFF_OPCTRL);
      chk("set_wins", rd_d, 32'h0000008B);
      nrst <= 1'b0;
      wt(2);
      nrst <= 1'b1;
      wt(1);
      rd(`NFCOMC_OFF_OPCTRL);
      chk("opctrl_keep", rd_d, 32'h0000008B);
      ce <= 1'b0;
      pulse(1'b0);
      ce <= 1'b1;
      wt(1);
      rd(`NFCOMC_OFF_OPCTRL);
      chk("ce_freeze", rd_d, 32'h0000008B);
      $display("test tx and reset done");
      wr(`NFCOMC_OFF_MODEDEF, 8'hFF);
      rd(`NFCOMC_OFF_MODEDEF);
      chk("md_noxtal", rd_d, 32'h00000008);
      rd(`NFCOMC_OFF_EVENTS);
      chk("ign_evt", rd_d, 32'h00000001);
      rd(`NFCOMC_OFF_EVENTS);
      chk("ign_clr", rd_d, 32'h00000000);
      xtal_stable_pin <= 1'b1;
      wt(8);
      wr(`NFCOMC_OFF_MODEDEF, 8'hFF);
      chk("wr_okay", rsp, 2'h0);
      rd(`NFCOMC_OFF_MODEDEF);
      chk("md_mask", rd_d, 32'h000000FC);
      chk("role", target_role, 1'b1);
      chk("mod_style", modulation_style, 1'b1);
      rd(`NFCOMC_OFF_STATUS);
      chk("status", rd_d, 32'h00000003);
      wr(`NFCOMC_OFF_OPCTRL, 8'hC8);
      for (i = 0; i < 16; i++) begin
         wr(`NFCOMC_OFF_MODEDEF, {1'b0, i[3:0], 3'h0});
         chk("ps", protocol_select, i[3:0]);
         chk("supported", mode_supported, i == 1 || i == 2 || i == 4 || i > 13);
         chk("tx_gate", tx_enable, i == 1 || i == 2 || i == 4 || i > 13);
         chk("rx_gate", rx_enable, i == 1 || i == 2 || i == 4 || i > 13);
      end
      wr(`NFCOMC_OFF_MODEDEF, 8'hA0);
      chk("tgt_f", mode_supported, 1'b1);
      wr(`NFCOMC_OFF_MODEDEF, 8'hB0);
      chk("tgt_bad", mode_supported, 1'b0);
      // Prefix option stays off while in rate detection
      wr(`NFCOMC_OFF_MODEDEF, 8'hE8);
      chk("brd_fa", {brd_type_f, brd_type_a}, 2'h3);
      wr(`NFCOMC_OFF_MODEDEF, 8'hE0);
      chk("brd_f", {brd_type_f, brd_type_a}, 2'h2);
      // Leave rate detection before the prefix option
      wr(`NFCOMC_OFF_MODEDEF, 8'h08);
      $display("test mode done");
      wr(`NFCOMC_OFF_PREFIX, 8'h01);
      chk("prefix", {transport_frame_prefix, tx_add_prefix}, 2'h3);
      chk("start_byte", tx_prefix_byte0, 8'hF0);
      chk("len_byte", tx_prefix_byte1, 8'h5A);
      {rx_byte_valid, rx_first_byte} <= 2'h3;
      wt(2);
      chk("rx_skip", rx_skip_byte, 1'b1);
      {rx_byte_valid, rx_first_byte} <= 2'h0;
      wt(2);
      chk("rx_skip_end", rx_skip_byte, 1'b0);
      wr(`NFCOMC_OFF_PREFIX, 8'h00);
      chk("prefix_off", tx_add_prefix, 1'b0);
      wr(8'h40, 8'h55);
      chk("wr_unmapped", rsp, 2'h2);
      rd(8'h40);
      chk("rd_unmapped", rsp, 2'h2);
      $display("test prefix and map done");
      print_verdict();
   end
endmodule // tb_top
